// File: include/udw_store_consts.svh
// named constants of the unaligned doubleword store unit
`ifndef UDW_STORE_CONSTS_SVH
`define UDW_STORE_CONSTS_SVH

`define OPC_HI            31
`define OPC_LO            26
`define BASE_HI           25
`define BASE_LO           21
`define SRC_HI            20
`define SRC_LO            16
`define IMM_HI            15
`define IMM_SIGN          15
`define OPC_STORE_LEFT    6'h2C
`define OPC_STORE_RIGHT   6'h2D
`define DWORD_TYPE        3'h7
`define OFFSET_ZERO       3'h0
`define WORD_SIGN         31
`define RESET_DATA        64'h0000_0000_0000_0000
`define RESET_OFFSET      3'h0

`endif

// File: include/udw_store_pkg.sv
// types shared by the unaligned doubleword store unit
package udw_store_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } state_t;

  typedef enum logic [2:0] {
    EXC_NONE     = 3'h0,
    EXC_RESERVED = 3'h1,
    EXC_TLB_MISS = 3'h2,
    EXC_TLB_INV  = 3'h3,
    EXC_TLB_MOD  = 3'h4,
    EXC_BUS_ERR  = 3'h5
  } exc_t;

endpackage

// File: include/udw_shift_if.sv
// store data alignment signals between the unit and its shifter
`timescale 1ns/1ps
`default_nettype none

interface udw_shift_if;
  logic [63:0] src;
  logic [2:0]  byteIdx;
  logic        leftStore;
  logic [63:0] result;

  modport requester
  (
    output src,
    output byteIdx,
    output leftStore,
    input  result
  );

  modport shifter
  (
    input  src,
    input  byteIdx,
    input  leftStore,
    output result
  );
endinterface // udw_shift_if

`default_nettype wire

// File: verilog/udw_store_shifter.sv
// byte-lane alignment of store data for the left and right stores
`timescale 1ns/1ps
`default_nettype none

module udw_store_shifter
(
  udw_shift_if.shifter sh
);

  logic [5:0] leftAmount;
  logic [5:0] rightAmount;

  // 56 - 8*byte equals 8 * (7 - byte), which is 8 * ~byte
  always_comb
  begin
    leftAmount  = {~sh.byteIdx, 3'h0};
    rightAmount = {sh.byteIdx, 3'h0};
    if (sh.leftStore)
    begin
      sh.result = sh.src >> leftAmount;
    end
    else
    begin
      sh.result = sh.src << rightAmount;
    end
  end

endmodule // udw_store_shifter

`default_nettype wire

// File: verilog/unaligned_dword_store_unit.sv
// execution and store alignment of the unaligned doubleword stores
`timescale 1ns/1ps
`default_nettype none
`include "udw_store_consts.svh"

module unaligned_dword_store_unit
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        instValid,
  input  wire logic [31:0] instWord,
  input  wire logic [63:0] baseValue,
  input  wire logic [63:0] sourceValue,
  input  wire logic        mode64,
  input  wire logic        kernelMode,
  input  wire logic        cpuBigEndianFlag,
  input  wire logic        memoryBigEndianFlag,
  input  wire logic        reverseEndianFlag,
  input  wire logic        memReady,
  input  wire logic        tlbMissIn,
  input  wire logic        tlbInvalidIn,
  input  wire logic        tlbModifyIn,
  input  wire logic        busErrorIn,
  output logic             busy,
  output logic             storeValid,
  output logic             storeLeft,
  output logic [63:0]      virtualAddress,
  output logic [2:0]       addrOffset,
  output logic [2:0]       accessType,
  output logic [63:0]      storeData,
  output logic             excValid,
  output logic [2:0]       excCode
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode and address formation

  udw_shift_if shIf ();

  logic [5:0]  opcode;
  logic [63:0] immExt;
  logic [31:0] sum32;
  logic [63:0] effAddr;
  logic        isLeft;
  logic        isRight;
  logic        modeOk;
  logic [2:0]  byteIdx;
  logic [2:0]  typeCode;
  logic [2:0]  offsetCode;

  // register numbers are not decoded here; their values arrive already read
  assign opcode              = instWord[`OPC_HI:`OPC_LO];
  assign isLeft              = (opcode == `OPC_STORE_LEFT);
  assign isRight             = (opcode == `OPC_STORE_RIGHT);
  assign modeOk              = mode64 | kernelMode;

  always_comb
  begin
    immExt = {{48{instWord[`IMM_SIGN]}}, instWord[`IMM_HI:0]};
    sum32  = immExt[31:0] + baseValue[31:0];
    if (mode64)
    begin
      effAddr = immExt + baseValue;
    end
    else
    begin
      // upper base half dropped; result kept as a sign-extended word
      effAddr = {{32{sum32[`WORD_SIGN]}}, sum32};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // endianness, access type, offset

  // no alignment check at all: any low address bits are legal here
  always_comb
  begin
    byteIdx = effAddr[2:0] ^ {3{cpuBigEndianFlag}};
    if (isLeft)
    begin
      typeCode = byteIdx;
    end
    else
    begin
      typeCode = `DWORD_TYPE - byteIdx;
    end
    if (!memoryBigEndianFlag)
    begin
      offsetCode = `OFFSET_ZERO;
    end
    else if (isLeft)
    begin
      offsetCode = effAddr[2:0] ^ {3{~cpuBigEndianFlag}} ^ {3{reverseEndianFlag}};
    end
    else
    begin
      offsetCode = effAddr[2:0] ^ {3{reverseEndianFlag}};
    end
  end

  assign shIf.src       = sourceValue;
  assign shIf.byteIdx   = byteIdx;
  assign shIf.leftStore = isLeft;

  // left store moves the top bytes down, right store the bottom bytes up
  udw_store_shifter u_shifter
  (
    .sh (shIf.shifter)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // request sequencing

  udw_store_pkg::state_t state_q;
  udw_store_pkg::state_t state_d;
  logic        valid_q;
  logic        valid_d;
  logic        left_q;
  logic        left_d;
  logic [63:0] virtual_address_q;
  logic [63:0] virtual_address_d;
  logic [2:0]  offset_q;
  logic [2:0]  offset_d;
  logic [2:0]  type_q;
  logic [2:0]  type_d;
  logic [63:0] data_q;
  logic [63:0] data_d;
  logic        exc_q;
  logic        exc_d;
  udw_store_pkg::exc_t code_q;
  udw_store_pkg::exc_t code_d;
  logic        fault;

  assign fault = tlbMissIn | tlbInvalidIn | tlbModifyIn | busErrorIn;

  always_comb
  begin
    state_d  = state_q;
    valid_d  = valid_q;
    left_d   = left_q;
    virtual_address_d  = virtual_address_q;
    offset_d = offset_q;
    type_d   = type_q;
    data_d   = data_q;
    exc_d    = 1'b0;
    code_d   = code_q;
    case (state_q)
      udw_store_pkg::ST_IDLE:
      begin
        if (instValid && (isLeft || isRight))
        begin
          if (!modeOk)
          begin
            exc_d  = 1'b1;
            code_d = udw_store_pkg::EXC_RESERVED;
          end
          else
          begin
            // each pair half is an independent request
            state_d  = udw_store_pkg::ST_WAIT;
            valid_d  = 1'b1;
            left_d   = isLeft;
            virtual_address_d  = effAddr;
            offset_d = offsetCode;
            type_d   = typeCode;
            data_d   = shIf.result;
          end
        end
      end
      udw_store_pkg::ST_WAIT:
      begin
        // a fault ends the request even if memReady is seen together
        if (fault)
        begin
          state_d = udw_store_pkg::ST_IDLE;
          valid_d = 1'b0;
          exc_d   = 1'b1;
          if (tlbMissIn)
          begin
            code_d = udw_store_pkg::EXC_TLB_MISS;
          end
          else if (tlbInvalidIn)
          begin
            code_d = udw_store_pkg::EXC_TLB_INV;
          end
          else if (tlbModifyIn)
          begin
            code_d = udw_store_pkg::EXC_TLB_MOD;
          end
          else
          begin
            code_d = udw_store_pkg::EXC_BUS_ERR;
          end
        end
        else if (memReady)
        begin
          state_d = udw_store_pkg::ST_IDLE;
          valid_d = 1'b0;
        end
      end
      default:
      begin
        state_d = udw_store_pkg::ST_IDLE;
        valid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q  <= udw_store_pkg::ST_IDLE;
      valid_q  <= 1'b0;
      left_q   <= 1'b0;
      virtual_address_q  <= `RESET_DATA;
      offset_q <= `RESET_OFFSET;
      type_q   <= `RESET_OFFSET;
      data_q   <= `RESET_DATA;
      exc_q    <= 1'b0;
      code_q   <= udw_store_pkg::EXC_NONE;
    end
    else
    begin
      state_q  <= state_d;
      valid_q  <= valid_d;
      left_q   <= left_d;
      virtual_address_q  <= virtual_address_d;
      offset_q <= offset_d;
      type_q   <= type_d;
      data_q   <= data_d;
      exc_q    <= exc_d;
      code_q   <= code_d;
    end
  end

  assign busy           = (state_q == udw_store_pkg::ST_WAIT);
  assign storeValid     = valid_q;
  assign storeLeft      = left_q;
  assign virtualAddress = virtual_address_q;
  assign addrOffset     = offset_q;
  assign accessType     = type_q;
  assign storeData      = data_q;
  assign excValid       = exc_q;
  assign excCode        = code_q;

endmodule // unaligned_dword_store_unit

`default_nettype wire

// File: testbench/udw_mem_model.sv
// memory side model answering store requests of the unit
`timescale 1ns/1ps
`default_nettype none

module udw_mem_model
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       storeValid,
  input  wire logic [3:0] waitCycles,
  input  wire logic [3:0] faultVec,
  output logic            memReady,
  output logic            tlbMissIn,
  output logic            tlbInvalidIn,
  output logic            tlbModifyIn,
  output logic            busErrorIn
);
  logic [3:0] cnt;
  logic       ack;
  // ready stays up with a fault so the fault priority is exercised
  assign memReady = ack;
  assign {busErrorIn, tlbModifyIn, tlbInvalidIn, tlbMissIn} = ack ? faultVec : 4'h0;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      cnt <= 4'h0;
      ack <= 1'b0;
    end
    else
    begin
      ack <= storeValid && !ack && cnt == waitCycles;
      cnt <= (storeValid && !ack) ? cnt + 4'h1 : 4'h0;
    end
endmodule // udw_mem_model

`default_nettype wire

// File: testbench/udw_store_asserts.sv
// port assertions of the unaligned doubleword store unit
`timescale 1ns/1ps
`default_nettype none

module udw_store_asserts
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        instValid,
  input wire logic [31:0] instWord,
  input wire logic [63:0] baseValue,
  input wire logic        mode64,
  input wire logic        kernelMode,
  input wire logic        cpuBigEndianFlag,
  input wire logic        memoryBigEndianFlag,
  input wire logic        reverseEndianFlag,
  input wire logic        memReady,
  input wire logic        tlbMissIn,
  input wire logic        busy,
  input wire logic        storeValid,
  input wire logic        storeLeft,
  input wire logic [63:0] virtualAddress,
  input wire logic [2:0]  addrOffset,
  input wire logic [2:0]  accessType,
  input wire logic        excValid,
  input wire logic [2:0]  excCode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] idx;
  logic       isSt;
  assign idx = virtualAddress[2:0] ^ {3{cpuBigEndianFlag}};
  // both opcodes share their top five bits
  assign isSt = instValid && !busy && instWord[31:27] == 5'h16;
  sequence sTake;
    isSt && (mode64 || kernelMode);
  endsequence
  sequence sRsv;
    isSt && !mode64 && !kernelMode;
  endsequence
  AST_EA: assert property (sTake ##0 mode64 |=> storeValid && virtualAddress ==
    $past(baseValue) + {{48{$past(instWord[15])}}, $past(instWord[15:0])})
    else $error("effective address wrong");
  AST_NOERR: assert property (sTake |=> !excValid)
    else $error("exception on accepted store");
  AST_RSV: assert property (sRsv |=> excValid && excCode == 3'h1 && !storeValid)
    else $error("reserved instruction not raised");
  AST_HOLD: assert property (storeValid ##1 storeValid |-> $stable(virtualAddress) &&
    $stable(accessType) && $stable(addrOffset) && $stable(storeLeft))
    else $error("request changed while outstanding");
  AST_LEM: assert property (storeValid && !memoryBigEndianFlag |-> addrOffset == 3'h0)
    else $error("offset not zero for little-endian memory");
  AST_LTYPE: assert property (storeValid && storeLeft |-> accessType == idx)
    else $error("left store type wrong");
  AST_LOFF: assert property (storeValid && storeLeft && memoryBigEndianFlag &&
    !cpuBigEndianFlag && !reverseEndianFlag |-> addrOffset == 3'h7 - virtualAddress[2:0])
    else $error("left store offset wrong");
  AST_RTYPE: assert property (storeValid && !storeLeft |-> accessType == 3'h7 - idx)
    else $error("right store type wrong");
  AST_DONE: assert property (storeValid && memReady |=> !storeValid)
    else $error("store not retired");
  AST_MISS: assert property (storeValid && tlbMissIn |=> excValid && excCode == 3'h2
    ##1 !excValid)
    else $error("translation miss not reported");
endmodule // udw_store_asserts

bind unaligned_dword_store_unit udw_store_asserts chk (.*);

`default_nettype wire

// File: testbench/tb.sv
// self-checking bench of the unaligned doubleword store unit
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic sys_clk, reset_n, instValid, mode64, kernelMode, cpuBigEndianFlag;
  logic memoryBigEndianFlag, reverseEndianFlag, memReady, tlbMissIn, tlbInvalidIn;
  logic tlbModifyIn, busErrorIn, busy, storeValid, storeLeft, excValid;
  logic [31:0] instWord;
  logic [63:0] baseValue, sourceValue, virtualAddress, storeData;
  logic [2:0]  addrOffset, accessType, excCode;
  logic [3:0]  waitCycles, faultVec;
  int          nErrors, checkCount;

  unaligned_dword_store_unit DUT (.*);
  udw_mem_model mem (.*);

  task automatic endSim();
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    checkCount++;
    if (s !== e)
    begin
      nErrors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask

  // sel 1 watches excValid, sel 0 storeValid
  task automatic waitOut(input logic sel, input logic v);
    int k;
    k = 0;
    @(negedge sys_clk);
    while ((sel ? excValid : storeValid) !== v && k < 20)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 20)
    begin
      nErrors++;
      endSim();
    end
  endtask

  task automatic op(input logic [5:0] o, input logic [15:0] i, input logic [63:0] b);
    @(posedge sys_clk);
    instWord <= {o, 10'h041, i};
    baseValue <= b;
    instValid <= 1'b1;
    @(posedge sys_clk);
    instValid <= 1'b0;
  endtask

  task automatic store(input logic [5:0] o, input logic [15:0] i, input logic [63:0] b);
    logic [63:0] a;
    logic [2:0]  x;
    logic        lf;
    op(o, i, b);
    a = b + {{48{i[15]}}, i};
    a = mode64 ? a : {{32{a[31]}}, a[31:0]};
    lf = o == 6'h2C;
    x = a[2:0] ^ {3{cpuBigEndianFlag}};
    waitOut(1'b0, 1'b1);
    chk("va", virtualAddress, a);
    chk("left", storeLeft, lf);
    chk("busy", busy, 1'b1);
    chk("type", accessType, lf ? x : 3'h7 - x);
    chk("data", storeData, lf ? sourceValue >> (8 * (7 - x)) : sourceValue << (8 * x));
    chk("off", addrOffset, memoryBigEndianFlag ? a[2:0] ^ {3{reverseEndianFlag}} ^
      {3{lf & ~cpuBigEndianFlag}} : 3'h0);
    waitOut(1'b0, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // each pass issues a left then a right store back to back
  task automatic t_align();
    for (int n = 0; n < 32; n++)
    begin
      @(posedge sys_clk);
      cpuBigEndianFlag <= n[3];
      memoryBigEndianFlag <= n[4];
      reverseEndianFlag <= n[0];
      waitCycles <= 4'(n[1:0]);
      store(6'h2C, {13'h1FFE, n[2:0]}, 64'h0000_0001_0000_1000);
      store(6'h2D, {13'h1FFE, n[2:0]}, 64'h0000_0001_0000_1000);
    end
  endtask

  task automatic t_modes();
    @(posedge sys_clk);
    mode64 <= 1'b0;
    kernelMode <= 1'b1;
    store(6'h2D, 16'h0003, 64'hDEAD_BEEF_7FFF_FFFE);
    @(posedge sys_clk);
    kernelMode <= 1'b0;
    for (int n = 0; n < 2; n++)
    begin
      op(6'h2C | 6'(n), 16'h0000, 64'h0);
      waitOut(1'b1, 1'b1);
      chk("rsv", excCode, 3'h1);
      chk("nost", storeValid, 1'b0);
    end
    @(posedge sys_clk);
    mode64 <= 1'b1;
    op(6'h2B, 16'h0000, 64'h0);
    repeat (3) @(negedge sys_clk);
    chk("other", storeValid, 1'b0);
  endtask

  task automatic t_faults();
    logic [3:0] v[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h9};
    logic [2:0] c[5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h2};
    for (int n = 0; n < 5; n++)
    begin
      @(posedge sys_clk);
      faultVec <= v[n];
      waitCycles <= 4'h3;
      op(6'h2C, 16'h0005, 64'h100);
      waitOut(1'b1, 1'b1);
      chk("code", excCode, c[n]);
      chk("drop", storeValid, 1'b0);
      @(negedge sys_clk);
      chk("pulse", excValid, 1'b0);
    end
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial
  begin
    {reset_n, instValid, kernelMode, cpuBigEndianFlag} = 4'h0;
    {memoryBigEndianFlag, reverseEndianFlag, waitCycles, faultVec} = 10'h000;
    {instWord, baseValue} = 96'h0;
    mode64 = 1'b1;
    sourceValue = 64'h0123_4567_89AB_CDEF;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_align();
    t_modes();
    t_faults();
    endSim();
  end
endmodule // tb

`default_nettype wire
